// *** rtl/alarm_io_pkg.sv ***
package alarm_io_pkg;

   // Clock and timing
   localparam int CLK_HZ          = 50_000_000;
   localparam int DEBOUNCE_US     = 20;
   localparam int DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int BIAS_HOLD_MS    = 2500;
   localparam int BIAS_HOLD_CYC   = BIAS_HOLD_MS * (CLK_HZ / 1000);
   localparam int DEB_W           = 10;
   localparam int HOLD_W          = 27;

   // Register numbers, 16-bit words; a 32-bit register takes two, high word first
   localparam logic [15:0] ADDR_A1_FAULT_MASK = 16'hA39B;
   localparam logic [15:0] ADDR_A1_WARN_MASK  = 16'hA39D;
   localparam logic [15:0] ADDR_A2_FAULT_MASK = 16'hA39F;
   localparam logic [15:0] ADDR_A2_WARN_MASK  = 16'hA3A1;
   localparam logic [15:0] ADDR_POLARITY      = 16'hA3A3;
   localparam logic [15:0] ADDR_A1_STATE_MASK = 16'hA3A4;
   localparam logic [15:0] ADDR_A2_STATE_MASK = 16'hA3A6;
   localparam logic [15:0] ADDR_A1_MISC_MASK  = 16'hA3A8;
   localparam logic [15:0] ADDR_A2_MISC_MASK  = 16'hA3A9;
   localparam logic [15:0] ADDR_A1_GRID_MASK  = 16'hA3AD;
   localparam logic [15:0] ADDR_A2_GRID_MASK  = 16'hA3AF;
   localparam logic [15:0] ADDR_ISLAND_CFG    = 16'hA4F7;
   localparam logic [15:0] ADDR_WARN_STATUS   = 16'hA31C;
   localparam logic [15:0] ADDR_FAULT_STATUS  = 16'hA31E;
   localparam logic [15:0] ADDR_GRID_STATUS   = 16'h9C9B;

   // Word indices; writable store words below CFG_WORDS, read-only status words from CFG_WORDS up
   localparam int CFG_WORDS   = 20;
   localparam logic [4:0] IX_A1_FAULT = 5'h00;
   localparam logic [4:0] IX_A1_WARN  = 5'h02;
   localparam logic [4:0] IX_A2_FAULT = 5'h04;
   localparam logic [4:0] IX_A2_WARN  = 5'h06;
   localparam logic [4:0] IX_POLARITY = 5'h08;
   localparam logic [4:0] IX_A1_STATE = 5'h09;
   localparam logic [4:0] IX_A2_STATE = 5'h0B;
   localparam logic [4:0] IX_A1_MISC  = 5'h0D;
   localparam logic [4:0] IX_A2_MISC  = 5'h0E;
   localparam logic [4:0] IX_A1_GRID  = 5'h0F;
   localparam logic [4:0] IX_A2_GRID  = 5'h11;
   localparam logic [4:0] IX_ISLAND   = 5'h13;
   localparam logic [4:0] IX_FAULT_ST = 5'h14;
   localparam logic [4:0] IX_WARN_ST  = 5'h16;
   localparam logic [4:0] IX_GRID_ST  = 5'h18;
   localparam logic [4:0] IX_NONE     = 5'h1F;

   // Field positions and reset values
   localparam int POL_ONE_BIT        = 0;
   localparam int POL_TWO_BIT        = 1;
   localparam int ISLAND_EN_BIT      = 0;
   localparam int ISLAND_INV_BIT     = 1;
   localparam int EMERGENCY_STOP_ENABLE_FAULT_BIT    = 0;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   typedef logic [CFG_WORDS-1:0][15:0] cfg_t;

   typedef struct packed {
      logic [31:0] fault;
      logic [31:0] warn;
      logic [31:0] grid;
      logic [31:0] state;
      logic [15:0] misc;
   } status_t;

   typedef struct packed {
      logic             meta;
      logic             sync;
      logic             clean;
      logic [DEB_W-1:0] cnt;
   } filt_t;

   typedef struct packed {
      cfg_t              cfg;
      logic [15:0]       rdata;
      logic              rvalid;
      logic              rerr;
      logic              alarm_one;
      logic              alarm_two;
      logic              dc_en;
      logic              ac_en;
      logic              bias_on;
      logic [HOLD_W-1:0] hold_cnt;
      logic              island;
      logic              emergency_stop_enable_fault;
   } io_state_t;

endpackage

// *** rtl/input_filter.sv ***
`timescale 1ns/1ps
module input_filter
   import alarm_io_pkg::*;
(
   input  wire logic clk,    // System clock
   input  wire logic srst,   // Synchronous reset
   input  wire logic raw,    // Isolated input pin
   output logic      clean   // Synchronised, debounced level
);

   filt_t s_reg;
   filt_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      s_next      = s_reg;
      s_next.meta = raw;
      s_next.sync = s_reg.meta;
      // Only a level held for the full window is taken
      if (s_reg.sync == s_reg.clean)
      begin
         s_next.cnt = '0;
      end
      else if (s_reg.cnt == DEB_W'(DEBOUNCE_CYC - 1))
      begin
         s_next.clean = s_reg.sync;
         s_next.cnt   = '0;
      end
      else
      begin
         s_next.cnt = s_reg.cnt + DEB_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign clean = s_reg.clean;

endmodule

// *** rtl/discrete_alarm_io.sv ***
`timescale 1ns/1ps
// Function
// - Exactly two configurable alarm outputs.
// - Each output has five mask registers.
// - Output one fault/warning masks select status.
// - Output two masks select same status.
// - Grid alarm masks select grid status.
// - State masks select operating states.
// - Misc masks select internal functions.
// - Mask bit one enables condition, zero excludes.
// - Enabled conditions combined by OR.
// - Polarity register sets active output level.
// - Exactly three isolated discrete inputs.
// - Stop enable gates both contactor drives.
// - Stop fault flagged while enable absent.
// - Bias runs while request asserted.
// - Bias holds 2.5 s after request drops.
// - Island input configured through register.
module discrete_alarm_io
   import alarm_io_pkg::*;
#(
   parameter int BIAS_HOLD_CYCLES = BIAS_HOLD_CYC
)
(
   input  wire logic        CLK,                    // System clock, 50 MHz
   input  wire logic        SRST,                   // Synchronous reset, active high
   input  wire logic        EMERGENCY_STOP_ENABLE,  // Isolated stop enable pin
   input  wire logic        BIAS_REQUEST,           // Isolated bias on/off pin
   input  wire logic        ISLAND_CONTROL,         // Isolated island control pin
   input  wire status_t     STATUS_IN,              // Converter status vectors
   input  wire logic        DC_CONTACTOR_CMD,       // Controller DC contactor request
   input  wire logic        AC_CONTACTOR_CMD,       // Controller AC contactor request
   input  wire logic [15:0] REG_ADDR,               // Register number
   input  wire logic [15:0] REG_WDATA,              // Write word
   input  wire logic        REG_WR,                 // Write strobe
   input  wire logic        REG_RD,                 // Read strobe
   output logic      [15:0] REG_RDATA,              // Read word
   output logic             REG_RVALID,             // Read answer pulse
   output logic             REG_ERR,                // Bad access pulse
   output logic             ALARM_OUTPUT_ONE,       // Alarm output one
   output logic             ALARM_OUTPUT_TWO,       // Alarm output two
   output logic             DC_CONTACTOR_EN,        // DC contactor drive
   output logic             AC_CONTACTOR_EN,        // AC contactor drive
   output logic             BIAS_SUPPLY_ON,         // Bias supply enable
   output logic             ISLAND_REQUEST,         // Grid-forming request
   output logic             EMERGENCY_STOP_ENABLE_FAULT             // Stop fault flag
);

   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(BIAS_HOLD_CYCLES);

   io_state_t   s_reg;
   io_state_t   s_next;
   logic [2:0]  pins;
   logic [2:0]  clean;
   logic        emergency_stop_enable_db;
   logic        bias_db;
   logic        island_db;
   logic [31:0] fault_vec;

   ////////////////////////////////////////////////////////////////////////////
   // Three isolated inputs, each through its own filter
   assign pins = {ISLAND_CONTROL, BIAS_REQUEST, EMERGENCY_STOP_ENABLE};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_in
         input_filter i_input_filter (
            .clk   (CLK),
            .srst  (SRST),
            .raw   (pins[gi]),
            .clean (clean[gi])
         );
      end
   endgenerate

   assign emergency_stop_enable_db  = clean[0];
   assign bias_db   = clean[1];
   assign island_db = clean[2];

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] reg_index(input logic [15:0] a);
      logic [4:0] ix;
      ix = IX_NONE;
      if (a >= ADDR_A1_FAULT_MASK && a <= ADDR_A2_MISC_MASK)
         ix = 5'(a - ADDR_A1_FAULT_MASK);
      else if (a >= ADDR_A1_GRID_MASK && a <= ADDR_A2_GRID_MASK + 16'h0001)
         ix = 5'(a - ADDR_A1_GRID_MASK) + IX_A1_GRID;
      else if (a == ADDR_ISLAND_CFG)
         ix = IX_ISLAND;
      else if (a == ADDR_FAULT_STATUS || a == ADDR_FAULT_STATUS + 16'h0001)
         ix = 5'(a - ADDR_FAULT_STATUS) + IX_FAULT_ST;
      else if (a == ADDR_WARN_STATUS || a == ADDR_WARN_STATUS + 16'h0001)
         ix = 5'(a - ADDR_WARN_STATUS) + IX_WARN_ST;
      else if (a == ADDR_GRID_STATUS || a == ADDR_GRID_STATUS + 16'h0001)
         ix = 5'(a - ADDR_GRID_STATUS) + IX_GRID_ST;
      return ix;
   endfunction

   function automatic logic [31:0] mask32(input cfg_t c, input logic [4:0] hi);
      return {c[hi], c[hi + 5'h01]};
   endfunction

   // Masked conditions of one output, before polarity
   function automatic logic alarm_hit(input cfg_t c, input status_t st,
                                      input logic [31:0] fv, input logic [4:0] ixf,
                                      input logic [4:0] ixw, input logic [4:0] ixs,
                                      input logic [4:0] ixm, input logic [4:0] ixg);
      return (|(fv & mask32(c, ixf)))
           | (|(st.warn & mask32(c, ixw)))
           | (|(st.state & mask32(c, ixs)))
           | (|(st.misc & c[ixm]))
           | (|(st.grid & mask32(c, ixg)));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      fault_vec                  = STATUS_IN.fault;
      fault_vec[EMERGENCY_STOP_ENABLE_FAULT_BIT] = STATUS_IN.fault[EMERGENCY_STOP_ENABLE_FAULT_BIT] | s_reg.emergency_stop_enable_fault;
   end

   always_comb
   begin
      logic [4:0] ix;
      ix            = reg_index(REG_ADDR);
      s_next        = s_reg;
      s_next.rvalid = 1'b0;
      s_next.rerr   = 1'b0;

      // Register access, one word a cycle; writes win over a same-cycle read
      if (REG_WR)
      begin
         if (ix < 5'(CFG_WORDS))
            s_next.cfg[ix] = REG_WDATA;
         else
            s_next.rerr = 1'b1;
      end
      else if (REG_RD)
      begin
         s_next.rvalid = 1'b1;
         case (ix)
            IX_FAULT_ST:         s_next.rdata = fault_vec[31:16];
            IX_FAULT_ST + 5'h01: s_next.rdata = fault_vec[15:0];
            IX_WARN_ST:          s_next.rdata = STATUS_IN.warn[31:16];
            IX_WARN_ST + 5'h01:  s_next.rdata = STATUS_IN.warn[15:0];
            IX_GRID_ST:          s_next.rdata = STATUS_IN.grid[31:16];
            IX_GRID_ST + 5'h01:  s_next.rdata = STATUS_IN.grid[15:0];
            IX_NONE:
            begin
               s_next.rdata = 16'h0000;
               s_next.rerr  = 1'b1;
            end
            default:             s_next.rdata = s_reg.cfg[ix];
         endcase
      end

      // Two alarm outputs, polarity applied last
      s_next.alarm_one = alarm_hit(s_reg.cfg, STATUS_IN, fault_vec, IX_A1_FAULT,
                                   IX_A1_WARN, IX_A1_STATE, IX_A1_MISC, IX_A1_GRID)
                         ^ s_reg.cfg[IX_POLARITY][POL_ONE_BIT];
      s_next.alarm_two = alarm_hit(s_reg.cfg, STATUS_IN, fault_vec, IX_A2_FAULT,
                                   IX_A2_WARN, IX_A2_STATE, IX_A2_MISC, IX_A2_GRID)
                         ^ s_reg.cfg[IX_POLARITY][POL_TWO_BIT];

      // Contactors open on loss of stop enable, whatever the controller asks
      s_next.dc_en       = emergency_stop_enable_db & DC_CONTACTOR_CMD;
      s_next.ac_en       = emergency_stop_enable_db & AC_CONTACTOR_CMD;
      s_next.emergency_stop_enable_fault = ~emergency_stop_enable_db;

      // Bias hold-up gives the processor time for housekeeping
      if (bias_db)
      begin
         s_next.bias_on  = 1'b1;
         s_next.hold_cnt = HOLD_LOAD;
      end
      else if (s_reg.hold_cnt != '0)
      begin
         s_next.hold_cnt = s_reg.hold_cnt - HOLD_W'(1);
      end
      else
      begin
         s_next.bias_on = 1'b0;
      end

      s_next.island = s_reg.cfg[IX_ISLAND][ISLAND_EN_BIT]
                      & (island_db ^ s_reg.cfg[IX_ISLAND][ISLAND_INV_BIT]);
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         s_reg     <= '0;
         s_reg.cfg <= {CFG_WORDS{CFG_RESET}};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign REG_RDATA        = s_reg.rdata;
   assign REG_RVALID       = s_reg.rvalid;
   assign REG_ERR          = s_reg.rerr;
   assign ALARM_OUTPUT_ONE = s_reg.alarm_one;
   assign ALARM_OUTPUT_TWO = s_reg.alarm_two;
   assign DC_CONTACTOR_EN  = s_reg.dc_en;
   assign AC_CONTACTOR_EN  = s_reg.ac_en;
   assign BIAS_SUPPLY_ON   = s_reg.bias_on;
   assign ISLAND_REQUEST   = s_reg.island;
   assign EMERGENCY_STOP_ENABLE_FAULT      = s_reg.emergency_stop_enable_fault;

   ////////////////////////////////////////////////////////////////////////////
   a_dc_gate_open: assert property (@(posedge CLK) disable iff (SRST)
      !emergency_stop_enable_db |=> !DC_CONTACTOR_EN)
      else $error("DC contactor closed without stop enable");

   a_ac_gate_open: assert property (@(posedge CLK) disable iff (SRST)
      !emergency_stop_enable_db |=> !AC_CONTACTOR_EN && EMERGENCY_STOP_ENABLE_FAULT)
      else $error("AC contactor closed without stop enable");

   a_emergency_stop_enable_fault_flag: assert property (@(posedge CLK) disable iff (SRST)
      $fell(emergency_stop_enable_db) |=> EMERGENCY_STOP_ENABLE_FAULT ##1 fault_vec[EMERGENCY_STOP_ENABLE_FAULT_BIT])
      else $error("Stop fault not flagged");

   a_bias_running: assert property (@(posedge CLK) disable iff (SRST)
      bias_db [*2] |=> BIAS_SUPPLY_ON)
      else $error("Bias off while requested");

   a_bias_hold_up: assert property (@(posedge CLK) disable iff (SRST)
      $fell(bias_db) |-> ##1 BIAS_SUPPLY_ON [*2])
      else $error("Bias dropped without hold-up");

   a_alarm_one_fault: assert property (@(posedge CLK) disable iff (SRST)
      (|(fault_vec & mask32(s_reg.cfg, IX_A1_FAULT)))
      && !s_reg.cfg[IX_POLARITY][POL_ONE_BIT] |=> ALARM_OUTPUT_ONE)
      else $error("Masked fault did not raise output one");

   a_alarm_two_warn: assert property (@(posedge CLK) disable iff (SRST)
      (|(STATUS_IN.warn & mask32(s_reg.cfg, IX_A2_WARN)))
      && s_reg.cfg[IX_POLARITY][POL_TWO_BIT] |=> !ALARM_OUTPUT_TWO)
      else $error("Masked warning did not drive output two low");

   a_alarm_grid_one: assert property (@(posedge CLK) disable iff (SRST)
      (|(STATUS_IN.grid & mask32(s_reg.cfg, IX_A1_GRID)))
      && !s_reg.cfg[IX_POLARITY][POL_ONE_BIT] |=> ALARM_OUTPUT_ONE)
      else $error("Masked grid alarm did not raise output one");

   a_idle_polarity: assert property (@(posedge CLK) disable iff (SRST)
      (s_reg.cfg[IX_A2_FAULT +: 4] == '0) && (s_reg.cfg[IX_A2_STATE +: 2] == '0)
      && (s_reg.cfg[IX_A2_MISC] == '0) && (s_reg.cfg[IX_A2_GRID +: 2] == '0)
      |=> ALARM_OUTPUT_TWO == $past(s_reg.cfg[IX_POLARITY][POL_TWO_BIT]))
      else $error("Idle output two level wrong");

   a_read_answer: assert property (@(posedge CLK) disable iff (SRST)
      REG_RD && !REG_WR |=> REG_RVALID)
      else $error("Read not answered in one cycle");

   a_idle_one: assert property (@(posedge CLK) disable iff (SRST)
      (s_reg.cfg[IX_A1_FAULT +: 4] == '0) && (s_reg.cfg[IX_A1_STATE +: 2] == '0)
      && (s_reg.cfg[IX_A1_MISC] == '0) && (s_reg.cfg[IX_A1_GRID +: 2] == '0)
      |=> ALARM_OUTPUT_ONE == $past(s_reg.cfg[IX_POLARITY][POL_ONE_BIT]))
      else $error("Idle output one level wrong");

   a_alarm_one_warn: assert property (@(posedge CLK) disable iff (SRST)
      (|(STATUS_IN.warn & mask32(s_reg.cfg, IX_A1_WARN)))
      && !s_reg.cfg[IX_POLARITY][POL_ONE_BIT] |=> ALARM_OUTPUT_ONE)
      else $error("Masked warning did not raise output one");

   a_alarm_two_fault: assert property (@(posedge CLK) disable iff (SRST)
      (|(fault_vec & mask32(s_reg.cfg, IX_A2_FAULT)))
      && !s_reg.cfg[IX_POLARITY][POL_TWO_BIT] |=> ALARM_OUTPUT_TWO)
      else $error("Masked fault did not raise output two");

   a_alarm_one_state: assert property (@(posedge CLK) disable iff (SRST)
      (|(STATUS_IN.state & mask32(s_reg.cfg, IX_A1_STATE)))
      && !s_reg.cfg[IX_POLARITY][POL_ONE_BIT] |=> ALARM_OUTPUT_ONE)
      else $error("Masked state did not raise output one");

   a_alarm_two_misc: assert property (@(posedge CLK) disable iff (SRST)
      (|(STATUS_IN.misc & s_reg.cfg[IX_A2_MISC]))
      && !s_reg.cfg[IX_POLARITY][POL_TWO_BIT] |=> ALARM_OUTPUT_TWO)
      else $error("Masked function did not raise output two");

   a_island_off: assert property (@(posedge CLK) disable iff (SRST)
      !s_reg.cfg[IX_ISLAND][ISLAND_EN_BIT] |=> !ISLAND_REQUEST)
      else $error("Island request while disabled");

   a_island_follow: assert property (@(posedge CLK) disable iff (SRST)
      s_reg.cfg[IX_ISLAND][ISLAND_EN_BIT]
      && (island_db != s_reg.cfg[IX_ISLAND][ISLAND_INV_BIT]) |=> ISLAND_REQUEST)
      else $error("Island request not raised");

   a_dc_gate_close: assert property (@(posedge CLK) disable iff (SRST)
      emergency_stop_enable_db && DC_CONTACTOR_CMD |=> DC_CONTACTOR_EN)
      else $error("DC contactor not closed on request");

   a_write_refused: assert property (@(posedge CLK) disable iff (SRST)
      REG_WR && (reg_index(REG_ADDR) >= 5'(CFG_WORDS)) |=> REG_ERR && !REG_RVALID)
      else $error("Refused write not flagged");

   a_bad_read: assert property (@(posedge CLK) disable iff (SRST)
      REG_RD && !REG_WR && (reg_index(REG_ADDR) == IX_NONE)
      |=> REG_ERR && (REG_RDATA == 16'h0000))
      else $error("Unmapped read not flagged");

   // Filtered level may only follow a pin level seen through both stages
   a_stop_synced: assert property (@(posedge CLK) disable iff (SRST)
      $rose(emergency_stop_enable_db) |-> $past(EMERGENCY_STOP_ENABLE, 3) && $past(EMERGENCY_STOP_ENABLE, 8))
      else $error("Stop enable passed without filtering");

endmodule

// *** dv/site_ctrl_model.sv ***
`timescale 1ns/1ps
module site_ctrl_model
(
   input  wire logic       clk,        // System clock
   input  wire logic [2:0] req,        // Wanted levels: stop enable, bias, island
   output logic            stop_pin,   // Stop enable line
   output logic            bias_pin,   // Bias request line
   output logic            island_pin  // Island control line
);
   logic [2:0]      last_reg   = 3'h0;
   logic [2:0]      pin_reg    = 3'h0;
   logic [2:0][1:0] bounce_reg = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // Relay contacts chatter on every change, so the filter sees no clean edge
   always @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         last_reg[i] <= req[i];
         if (req[i] != last_reg[i])
            bounce_reg[i] <= 2'h3;
         else if (bounce_reg[i] != 2'h0)
            bounce_reg[i] <= bounce_reg[i] - 2'h1;
         pin_reg[i] <= (bounce_reg[i] != 2'h0) ? ~pin_reg[i] : last_reg[i];
      end
   end
   assign stop_pin   = pin_reg[0];
   assign bias_pin   = pin_reg[1];
   assign island_pin = pin_reg[2];
endmodule

// *** dv/discrete_alarm_io_tb_top.sv ***
`timescale 1ns/1ps
module discrete_alarm_io_tb_top;
   import alarm_io_pkg::*;
   localparam int HOLD = 20;
   localparam logic [15:0] MASK_LOW [2][5] = '{
      '{ADDR_A1_FAULT_MASK + 16'h1, ADDR_A1_WARN_MASK + 16'h1, ADDR_A1_GRID_MASK + 16'h1,
        ADDR_A1_STATE_MASK + 16'h1, ADDR_A1_MISC_MASK},
      '{ADDR_A2_FAULT_MASK + 16'h1, ADDR_A2_WARN_MASK + 16'h1, ADDR_A2_GRID_MASK + 16'h1,
        ADDR_A2_STATE_MASK + 16'h1, ADDR_A2_MISC_MASK}};
   logic        CLK = 1'b0, SRST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   logic        DC_CONTACTOR_CMD = 1'b0, AC_CONTACTOR_CMD = 1'b0;
   logic [15:0] REG_ADDR = 16'h0000, REG_WDATA = 16'h0000, REG_RDATA;
   status_t     STATUS_IN = '0;
   logic        REG_RVALID, REG_ERR, ALARM_OUTPUT_ONE, ALARM_OUTPUT_TWO, EMERGENCY_STOP_ENABLE_FAULT;
   logic        DC_CONTACTOR_EN, AC_CONTACTOR_EN, BIAS_SUPPLY_ON, ISLAND_REQUEST;
   logic        EMERGENCY_STOP_ENABLE, BIAS_REQUEST, ISLAND_CONTROL, wr_err;
   logic [2:0]  line_req = 3'h0;
   int          fail_count = 0;
   int          compares = 0;
   int          n;

   discrete_alarm_io #(.BIAS_HOLD_CYCLES(HOLD)) i_discrete_alarm_io (
      .CLK(CLK), .SRST(SRST), .EMERGENCY_STOP_ENABLE(EMERGENCY_STOP_ENABLE),
      .BIAS_REQUEST(BIAS_REQUEST), .ISLAND_CONTROL(ISLAND_CONTROL), .STATUS_IN(STATUS_IN),
      .DC_CONTACTOR_CMD(DC_CONTACTOR_CMD), .AC_CONTACTOR_CMD(AC_CONTACTOR_CMD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR),
      .ALARM_OUTPUT_ONE(ALARM_OUTPUT_ONE), .ALARM_OUTPUT_TWO(ALARM_OUTPUT_TWO),
      .DC_CONTACTOR_EN(DC_CONTACTOR_EN), .AC_CONTACTOR_EN(AC_CONTACTOR_EN),
      .BIAS_SUPPLY_ON(BIAS_SUPPLY_ON), .ISLAND_REQUEST(ISLAND_REQUEST),
      .EMERGENCY_STOP_ENABLE_FAULT(EMERGENCY_STOP_ENABLE_FAULT));
   site_ctrl_model i_site_ctrl_model (.clk(CLK), .req(line_req),
      .stop_pin(EMERGENCY_STOP_ENABLE), .bias_pin(BIAS_REQUEST), .island_pin(ISLAND_CONTROL));

   initial
   begin
      forever #10 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic settle(input int cyc);
      repeat (cyc) @(posedge CLK);
      #1;
   endtask
   // Error pulse is caught in either of the two cycles after the write edge
   task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data);
      @(posedge CLK);
      REG_ADDR  <= addr;
      REG_WDATA <= data;
      REG_WR    <= 1'b1;
      @(posedge CLK);
      REG_WR    <= 1'b0;
      #1;
      wr_err = REG_ERR;
      settle(1);
      wr_err = wr_err | REG_ERR;
   endtask
   task automatic reg_rd(input logic [15:0] addr, input logic [15:0] exp, input logic bad);
      @(posedge CLK);
      REG_ADDR <= addr;
      REG_RD   <= 1'b1;
      @(posedge CLK);
      REG_RD   <= 1'b0;
      #1;
      repeat (3) if (REG_RVALID !== 1'b1) settle(1);
      check("read valid", REG_RVALID, 1'b1);
      check("read word", REG_RDATA, exp);
      check("read error", REG_ERR, bad);
   endtask
   task automatic apply(input status_t st, input logic e1, input logic e2);
      @(posedge CLK);
      STATUS_IN <= st;
      settle(2);
      check("alarm one", ALARM_OUTPUT_ONE, e1);
      check("alarm two", ALARM_OUTPUT_TWO, e2);
   endtask
   function automatic status_t flag(input int k, input int b);
      status_t st;
      st = '0;
      case (k)
         0: st.fault[b] = 1'b1;
         1: st.warn[b]  = 1'b1;
         2: st.grid[b]  = 1'b1;
         3: st.state[b] = 1'b1;
         default: st.misc[b] = 1'b1;
      endcase
      return st;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      check("stop fault after reset", EMERGENCY_STOP_ENABLE_FAULT, 1'b1);
      apply('0, 1'b0, 1'b0);
      foreach (MASK_LOW[o, k]) reg_rd(MASK_LOW[o][k], 16'h0000, 1'b0);
      reg_wr(ADDR_A1_FAULT_MASK, 16'h1234);
      reg_wr(ADDR_A1_FAULT_MASK + 16'h1, 16'hABCD);
      reg_rd(ADDR_A1_FAULT_MASK, 16'h1234, 1'b0);
      reg_rd(ADDR_A1_FAULT_MASK + 16'h1, 16'hABCD, 1'b0);
      reg_wr(ADDR_A1_FAULT_MASK, 16'h0000);
      reg_wr(ADDR_A1_FAULT_MASK + 16'h1, 16'h0000);
      reg_rd(16'hA3AA, 16'h0000, 1'b1);
      reg_wr(16'hA3AA, 16'hFFFF);
      check("unmapped write error", wr_err, 1'b1);
      reg_wr(ADDR_FAULT_STATUS, 16'hFFFF);
      check("status write error", wr_err, 1'b1);
      @(posedge CLK);
      STATUS_IN <= status_t'({32'h00F00002, 32'h12345678, 32'h9ABCDEF0, 32'h0, 16'h0});
      reg_rd(ADDR_WARN_STATUS, 16'h1234, 1'b0);
      reg_rd(ADDR_WARN_STATUS + 16'h1, 16'h5678, 1'b0);
      reg_rd(ADDR_GRID_STATUS, 16'h9ABC, 1'b0);
      reg_rd(ADDR_GRID_STATUS + 16'h1, 16'hDEF0, 1'b0);
      reg_rd(ADDR_FAULT_STATUS, 16'h00F0, 1'b0);
      reg_rd(ADDR_FAULT_STATUS + 16'h1, 16'h0003, 1'b0);
   endtask
   // Bit 5 of every category on each output, then an unmasked neighbour bit
   task automatic t_masks();
      for (int o = 0; o < 2; o++)
         for (int k = 0; k < 5; k++)
         begin
            reg_wr(MASK_LOW[o][k], 16'h0020);
            apply(flag(k, 5), o == 0, o == 1);
            apply(flag(k, 6), 1'b0, 1'b0);
            reg_wr(MASK_LOW[o][k], 16'h0000);
         end
   endtask
   task automatic t_or_pol();
      reg_wr(ADDR_A2_FAULT_MASK, 16'h0010);
      reg_wr(ADDR_A2_GRID_MASK + 16'h1, 16'h0002);
      apply(flag(0, 20), 1'b0, 1'b1);
      apply(flag(2, 1), 1'b0, 1'b1);
      apply(status_t'({32'h00100000, 32'h0, 32'h2, 32'h0, 16'h0}), 1'b0, 1'b1);
      apply(flag(0, 21), 1'b0, 1'b0);
      reg_wr(ADDR_POLARITY, 16'h0003);
      apply('0, 1'b1, 1'b1);
      reg_wr(ADDR_POLARITY, 16'h0002);
      apply(flag(2, 1), 1'b0, 1'b0);
      reg_wr(ADDR_A2_WARN_MASK, 16'h0001);
      apply(flag(1, 16), 1'b0, 1'b0);
      reg_wr(ADDR_A2_WARN_MASK, 16'h0000);
      apply('0, 1'b0, 1'b1);
      reg_wr(ADDR_POLARITY, 16'h0000);
      reg_wr(ADDR_A2_FAULT_MASK, 16'h0000);
      reg_wr(ADDR_A2_GRID_MASK + 16'h1, 16'h0000);
      apply('0, 1'b0, 1'b0);
   endtask
   task automatic t_emergency_stop_enable();
      @(posedge CLK);
      line_req[0] <= 1'b1;
      n = 0;
      while (EMERGENCY_STOP_ENABLE_FAULT !== 1'b0 && n < 1100)
      begin
         settle(1);
         n++;
      end
      check("stop filter delay", n >= DEBOUNCE_CYC && n < 1100, 1'b1);
      @(posedge CLK);
      DC_CONTACTOR_CMD <= 1'b1;
      AC_CONTACTOR_CMD <= 1'b1;
      settle(2);
      check("contactors closed", {DC_CONTACTOR_EN, AC_CONTACTOR_EN}, 2'b11);
      @(posedge CLK);
      DC_CONTACTOR_CMD <= 1'b0;
      settle(2);
      check("dc released", {DC_CONTACTOR_EN, AC_CONTACTOR_EN}, 2'b01);
      @(posedge CLK);
      DC_CONTACTOR_CMD <= 1'b1;
      line_req[0] <= 1'b0;
      repeat (1100) if (EMERGENCY_STOP_ENABLE_FAULT !== 1'b1) settle(1);
      check("stop fault", EMERGENCY_STOP_ENABLE_FAULT, 1'b1);
      check("contactors open", {DC_CONTACTOR_EN, AC_CONTACTOR_EN}, 2'b00);
      reg_wr(ADDR_A1_FAULT_MASK + 16'h1, 16'h0001);
      apply('0, 1'b1, 1'b0);
      reg_wr(ADDR_A1_FAULT_MASK + 16'h1, 16'h0000);
   endtask
   task automatic t_bias();
      @(posedge CLK);
      line_req[1] <= 1'b1;
      repeat (1100) if (BIAS_SUPPLY_ON !== 1'b1) settle(1);
      check("bias on", BIAS_SUPPLY_ON, 1'b1);
      @(posedge CLK);
      line_req[1] <= 1'b0;
      n = 0;
      while (BIAS_SUPPLY_ON !== 1'b0 && n < 1300)
      begin
         settle(1);
         n++;
      end
      check("bias hold", n > DEBOUNCE_CYC + HOLD && n < DEBOUNCE_CYC + HOLD + 12, 1'b1);
   endtask
   // A 50-cycle drop on the line must be swallowed by the filter
   task automatic t_island();
      reg_wr(ADDR_ISLAND_CFG, 16'h0001);
      @(posedge CLK);
      line_req[2] <= 1'b1;
      repeat (1100) if (ISLAND_REQUEST !== 1'b1) settle(1);
      check("island on", ISLAND_REQUEST, 1'b1);
      reg_wr(ADDR_ISLAND_CFG, 16'h0003);
      check("island inverted", ISLAND_REQUEST, 1'b0);
      reg_wr(ADDR_ISLAND_CFG, 16'h0001);
      @(posedge CLK);
      line_req[2] <= 1'b0;
      repeat (50) @(posedge CLK);
      line_req[2] <= 1'b1;
      n = 0;
      repeat (1200)
      begin
         settle(1);
         if (ISLAND_REQUEST !== 1'b1) n++;
      end
      check("island glitch", n, 0);
      reg_wr(ADDR_ISLAND_CFG, 16'h0000);
      check("island disabled", ISLAND_REQUEST, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge CLK);
      SRST <= 1'b0;
      settle(1);
      t_regs();
      t_masks();
      t_or_pol();
      t_emergency_stop_enable();
      t_bias();
      t_island();
      print_verdict();
   end
   initial
   begin
      repeat (60000) @(posedge CLK);
      fail_count++;
      print_verdict();
   end
endmodule
